// ===== bench/php_hw_model.sv
`timescale 1ns/10ps
module php_hw_model #(
	parameter int FRAME_BITS = 256
) (
	// Transmit line
	input wire logic tx_serial_out,
	input wire logic tx_serial_oe_n,
	// Highway
	output logic rx_bit_clock,
	output logic receive_frame_pulse,
	output logic rx_serial_in,
	output logic transmit_bit_clock,
	output logic transmit_frame_pulse,
	// Bytes seen
	output logic [7:0] got_byte,
	output logic got_tog
);
	int ri = 0;
	int ti = 0;
	int nb = 0;
	logic [7:0] sh;
	logic [4:0] s;
	initial begin
		receive_frame_pulse = 1'b0;
		rx_serial_in = 1'b0;
		got_tog = 1'b0;
		rx_bit_clock = 1'b0;
		#7;
		forever #16 rx_bit_clock = ~rx_bit_clock;
	end
	// Own phase: the two directions are unrelated
	initial begin
		transmit_frame_pulse = 1'b0;
		transmit_bit_clock = 1'b0;
		#19;
		forever #16 transmit_bit_clock = ~transmit_bit_clock;
	end
	always @(negedge rx_bit_clock) begin
		s = 5'(ri / 8);
		receive_frame_pulse <= (ri == 0);
		rx_serial_in <= {s, ~s[2:0]} >> (7 - ri % 8);
		ri <= (ri + 1) % FRAME_BITS;
	end
	// Sampled mid-bit, away from the launching edge
	always @(negedge transmit_bit_clock) begin
		transmit_frame_pulse <= (ti == FRAME_BITS - 1);
		ti <= (ti + 1) % FRAME_BITS;
		if (tx_serial_oe_n === 1'b0) begin
			sh = {sh[6:0], tx_serial_out};
			nb = nb + 1;
		end
		if (nb == 8) begin
			nb = 0;
			got_byte <= sh;
			got_tog <= ~got_tog;
		end
	end
endmodule: php_hw_model

// ===== bench/php_serial_port_tb.sv
`timescale 1ns/10ps
module php_serial_port_tb;
	logic clk, rst_n, rx_word_ready, tx_valid, tx_took, got_tog, tx_serial_out, tx_serial_oe_n;
	logic rx_bit_clock, receive_frame_pulse, rx_serial_in, transmit_bit_clock;
	logic transmit_frame_pulse, rx_word_valid, tx_ready, rx_overrun, rx_frame_err, tx_underrun;
	logic [7:0] rx_word_data, tx_byte, got_byte;
	logic [4:0] rx_word_chan;
	logic [31:0] tx_slot_en, seed;
	logic [12:0] rxq[$];
	logic [7:0] txq[$];
	int n_mismatch, checked, n_tx;
	php_serial_port dut_u (.clk, .rst_n, .fmt(php_pkg::PHP_CEPT), .odd_slots(1'b0), .tx_slot_en,
		.rx_bit_clock, .receive_frame_pulse, .rx_serial_in, .transmit_bit_clock,
		.transmit_frame_pulse, .tx_serial_out, .tx_serial_oe_n, .rx_word_valid, .rx_word_ready,
		.rx_word_data, .rx_word_chan, .tx_valid, .tx_ready, .tx_byte, .rx_overrun,
		.rx_frame_err, .tx_underrun);
	php_hw_model model_u (.tx_serial_out, .tx_serial_oe_n, .rx_bit_clock, .receive_frame_pulse,
		.rx_serial_in, .transmit_bit_clock, .transmit_frame_pulse, .got_byte, .got_tog);
	task automatic fail(input string m);
		n_mismatch++;
		$display("unexpected at %0t: %s", $time, m);
	endtask: fail
	task print_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask: print_verdict
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{n_mismatch, checked, n_tx} = '0;
		{rst_n, rx_word_ready, tx_valid, tx_took} = '0;
		seed = 32'h183f6871;
		tx_byte = 8'h3c;
		tx_slot_en = 32'h0;
		for (int i = 0; i < 320; i++)
			rxq.push_back({i[4:0], i[4:0], ~i[2:0]});
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		tx_valid = 1'b1;
		// No slot enabled: buffer fills and refuses
		repeat (400) @(negedge clk);
		checked++;
		if (tx_ready !== 1'b0) fail("tx buffer not full");
		tx_slot_en = $random(seed) | 32'h1;
		repeat (1200) @(negedge clk);
		if (rxq.size() > 150 || n_tx < 20) fail("traffic stalled");
		print_verdict();
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
	always @(posedge clk) tx_took <= tx_valid && tx_ready && rst_n;
	always @(negedge clk) begin
		if (rst_n) rx_word_ready <= ($random(seed) % 4) != 0;
		if (tx_took) begin
			txq.push_back(tx_byte);
			tx_byte <= 8'($random(seed));
		end
	end
	always @(posedge clk) begin
		if (rst_n && rx_word_valid && rx_word_ready) begin
			checked++;
			if ({rx_word_chan, rx_word_data} !== rxq.pop_front()) fail("rx word");
		end
		if (rst_n && (rx_frame_err !== 1'b0 || rx_overrun !== 1'b0)) fail("rx event");
		if (rst_n && tx_underrun !== 1'b0) fail("tx underrun");
	end
	always @(negedge transmit_bit_clock)
		if (rst_n && tx_slot_en == 0 && tx_serial_oe_n !== 1'b1) fail("line driven");
	always @(got_tog) begin
		if (rst_n) begin
			checked++;
			n_tx++;
			if (got_byte !== txq.pop_front()) fail("tx byte");
		end
	end
endmodule: php_serial_port_tb

// ===== bench/php_sp_chk.sv
`timescale 1ns/10ps
module php_sp_chk (
	// Clocks and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic transmit_bit_clock,
	// Watched ports
	input wire logic tx_serial_oe_n,
	input wire logic rx_word_valid,
	input wire logic rx_word_ready,
	input wire logic [7:0] rx_word_data,
	input wire logic [4:0] rx_word_chan,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_overrun,
	input wire logic rx_frame_err,
	input wire logic tx_underrun
);
	sequence s_head_held;
		rx_word_valid && $stable(rx_word_data) && $stable(rx_word_chan);
	endsequence
	sequence s_slot_driven;
		!tx_serial_oe_n [*8];
	endsequence
	AST_RX_HELD: assert property (@(posedge clk) disable iff (!rst_n)
		rx_word_valid && !rx_word_ready |=> s_head_held) else $error("rx head moved");
	AST_TX_SLOT: assert property (@(posedge transmit_bit_clock) disable iff (!rst_n)
		$fell(tx_serial_oe_n) |-> s_slot_driven) else $error("short drive run");
	AST_TX_FULL: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(tx_ready) |-> $past(tx_valid)) else $error("tx ready fell untaken");
	AST_OVR_FULL: assert property (@(posedge clk) disable iff (!rst_n)
		rx_overrun |-> $past(rx_word_valid)) else $error("overrun with room");
	AST_OVR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		rx_overrun |=> !rx_overrun) else $error("overrun too long");
	AST_ERR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		rx_frame_err |=> !rx_frame_err) else $error("frame error too long");
	AST_UND_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		tx_underrun |=> !tx_underrun) else $error("underrun too long");
	AST_RST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> tx_serial_oe_n && !rx_word_valid && tx_ready) else $error("not idle");
endmodule: php_sp_chk

bind php_serial_port php_sp_chk chk_u (.clk, .rst_n, .transmit_bit_clock, .tx_serial_oe_n,
	.rx_word_valid, .rx_word_ready, .rx_word_data, .rx_word_chan, .tx_valid, .tx_ready,
	.rx_overrun, .rx_frame_err, .tx_underrun);

// ===== hdl/php_buf2.sv
`timescale 1ns/10ps
module php_buf2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// Head and spare entry; the head feeds the outputs straight from flops
	typedef struct packed {
		logic ov;
		logic [WIDTH-1:0] od;
		logic sv;
		logic [WIDTH-1:0] sd;
	} php_buf_t;

	php_buf_t r;
	php_buf_t next_r;

	always_comb begin
		next_r = r;
		if (r.ov && out_ready) begin
			next_r.ov = r.sv;
			next_r.od = r.sd;
			next_r.sv = 1'b0;
		end
		// Full only when the spare holds a word
		if (in_valid && !r.sv) begin
			if (!next_r.ov) begin
				next_r.ov = 1'b1;
				next_r.od = in_data;
			end else begin
				next_r.sv = 1'b1;
				next_r.sd = in_data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign in_ready = ~r.sv;
	assign out_valid = r.ov;
	assign out_data = r.od;
endmodule: php_buf2

// ===== hdl/php_pkg.sv
package php_pkg;
	// Highway formats
	typedef enum logic [1:0] {PHP_T1_1544, PHP_T1_1536, PHP_CEPT, PHP_DOUBLE} php_fmt_t;

	// Highway bit rates and matching system clock, in kHz; frame period in us
	localparam int PHP_RATE_T1_1544_KHZ = 1544;
	localparam int PHP_RATE_T1_1536_KHZ = 1536;
	localparam int PHP_RATE_CEPT_KHZ = 2048;
	localparam int PHP_RATE_DOUBLE_KHZ = 4096;
	localparam int PHP_SYS_32CH_KHZ = 16384;
	localparam int PHP_SYS_T1_1536_KHZ = 12288;
	localparam int PHP_SYS_T1_1544_KHZ = 12352;
	localparam int PHP_FRAME_US = 125;

	// Index of the last bit of a frame, per format
	localparam logic [8:0] PHP_LAST_T1_1544 = 9'h0c0;
	localparam logic [8:0] PHP_LAST_T1_1536 = 9'h0bf;
	localparam logic [8:0] PHP_LAST_CEPT = 9'h0ff;
	localparam logic [8:0] PHP_LAST_DOUBLE = 9'h1ff;
	localparam logic [5:0] PHP_T1_SLOTS = 6'h18;

	// Bit index on the line when a transmit pulse edge is seen
	localparam logic [8:0] PHP_TX_LAG = 9'h002;
	localparam logic [7:0] PHP_IDLE_BYTE = 8'hff;
	localparam int PHP_RX_WORD_W = 13;
	localparam int PHP_TX_WORD_W = 8;

	function automatic logic [8:0] php_frame_last(input php_fmt_t fmt);
		unique case (fmt)
			PHP_T1_1544: return PHP_LAST_T1_1544;
			PHP_T1_1536: return PHP_LAST_T1_1536;
			PHP_CEPT: return PHP_LAST_CEPT;
			PHP_DOUBLE: return PHP_LAST_DOUBLE;
		endcase
	endfunction: php_frame_last
endpackage: php_pkg

// ===== hdl/php_rx_link.sv
`timescale 1ns/10ps
module php_rx_link (
	// Link side
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic frame_pulse,
	input wire logic serial_in,
	// Static configuration from the system domain
	input wire php_pkg::php_fmt_t fmt,
	input wire logic odd_slots,
	// Words and events, each marked by a toggle
	output logic [7:0] word,
	output logic [4:0] chan,
	output logic word_tog,
	output logic err_tog
);
	typedef struct packed {
		logic [1:0] p;
		logic [1:0] d;
		logic pl;
		logic [2:0] cf1;
		logic [2:0] cf2;
		logic [8:0] cnt;
		logic synced;
		logic [7:0] sh;
		logic [7:0] word;
		logic [4:0] chan;
		logic tog;
		logic err;
	} php_rx_t;

	php_rx_t r;
	php_rx_t next_r;
	php_pkg::php_fmt_t f;
	logic [8:0] last;
	logic [8:0] pos;
	logic [8:0] bp;
	logic edge_seen;
	logic fbit;
	logic own;

	always_comb begin
		next_r = r;
		// Pulse and data pass the same two stages, so they stay aligned
		next_r.p = {r.p[0], frame_pulse};
		next_r.d = {r.d[0], serial_in};
		next_r.pl = r.p[1];
		next_r.cf1 = {fmt, odd_slots};
		next_r.cf2 = r.cf1;
		f = php_pkg::php_fmt_t'(r.cf2[2:1]);
		last = php_pkg::php_frame_last(f);
		edge_seen = r.p[1] & ~r.pl;
		pos = (r.cnt == last) ? 9'h000 : r.cnt + 9'h001;
		if (edge_seen) begin
			// A pulse off the frame length means the source broke its period
			if (r.synced && r.cnt != last) begin
				next_r.err = ~r.err;
			end
			pos = 9'h000;
			next_r.synced = 1'b1;
		end
		next_r.cnt = pos;
		fbit = (f == php_pkg::PHP_T1_1544) && (pos == 9'h000);
		bp = (f == php_pkg::PHP_T1_1544) ? pos - 9'h001 : pos;
		own = (f != php_pkg::PHP_DOUBLE) || (bp[3] == r.cf2[0]);
		next_r.sh = {r.sh[6:0], r.d[1]};
		if ((r.synced || edge_seen) && !fbit && own && bp[2:0] == 3'h7) begin
			next_r.word = {r.sh[6:0], r.d[1]};
			next_r.chan = (f == php_pkg::PHP_DOUBLE) ? bp[8:4] : bp[7:3];
			next_r.tog = ~r.tog;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Held for a whole slot after each toggle, long enough to cross
	assign word = r.word;
	assign chan = r.chan;
	assign word_tog = r.tog;
	assign err_tog = r.err;
endmodule: php_rx_link

// ===== hdl/php_serial_port.sv
`timescale 1ns/10ps
module php_serial_port (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Static configuration
	input wire php_pkg::php_fmt_t fmt,
	input wire logic odd_slots,
	input wire logic [31:0] tx_slot_en,
	// Receive highway
	input wire logic rx_bit_clock,
	input wire logic receive_frame_pulse,
	input wire logic rx_serial_in,
	// Transmit highway
	input wire logic transmit_bit_clock,
	input wire logic transmit_frame_pulse,
	output logic tx_serial_out,
	output logic tx_serial_oe_n,
	// Received words
	output logic rx_word_valid,
	input wire logic rx_word_ready,
	output logic [7:0] rx_word_data,
	output logic [4:0] rx_word_chan,
	// Words to send
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_byte,
	// Events
	output logic rx_overrun,
	output logic rx_frame_err,
	output logic tx_underrun
);
	// System domain state
	typedef struct packed {
		logic [2:0] rxs;
		logic [2:0] errs;
		logic [2:0] reqs;
		logic ack;
		logic [7:0] reply;
		logic reply_act;
		logic rx_overrun;
		logic rx_frame_err;
		logic tx_underrun;
	} php_sys_t;

	// Transmit link domain state
	typedef struct packed {
		logic [1:0] p;
		logic pl;
		logic [2:0] cf1;
		logic [2:0] cf2;
		logic [2:0] aks;
		logic [8:0] cnt;
		logic synced;
		logic [7:0] sh;
		logic act;
		logic [7:0] pend;
		logic pact;
		logic req;
		logic [4:0] req_chan;
		logic late;
		logic dout;
		logic oe_n;
	} php_tx_t;

	// The line must be released from reset onward
	localparam php_tx_t TX_RESET = '{oe_n: 1'b1, default: '0};

	php_sys_t s;
	php_sys_t next_s;
	php_tx_t t;
	php_tx_t next_t;

	logic [7:0] rx_link_word;
	logic [4:0] rx_link_chan;
	logic rx_link_tog;
	logic rx_link_err;
	logic rx_push;
	logic rx_in_ready;
	logic tx_pop;
	logic tx_buf_valid;
	logic [7:0] tx_buf_data;
	logic req_new;
	logic need;

	// Link reset: taken at once, let go on each link's own clock edge
	logic [1:0] link_clk;
	logic [1:0] link_rst_n;

	assign link_clk = {transmit_bit_clock, rx_bit_clock};

	// A release near a link edge would otherwise free only some of its flops
	generate
		for (genvar i = 0; i < 2; i++) begin: g_rst_sync
			logic [1:0] q;
			always_ff @(posedge link_clk[i] or negedge rst_n) begin
				if (!rst_n) begin
					q <= 2'h0;
				end else begin
					q <= {q[0], 1'b1};
				end
			end
			assign link_rst_n[i] = q[1];
		end
	endgenerate

	// Receive link runs on its own clock and its own reset release

	php_rx_link u_rx_link (
		.link_clk(rx_bit_clock),
		.rst_n(link_rst_n[0]),
		.frame_pulse(receive_frame_pulse),
		.serial_in(rx_serial_in),
		.fmt(fmt),
		.odd_slots(odd_slots),
		.word(rx_link_word),
		.chan(rx_link_chan),
		.word_tog(rx_link_tog),
		.err_tog(rx_link_err)
	);

	// Two entries absorb a reader stall of one slot without loss
	php_buf2 #(
		.WIDTH(php_pkg::PHP_RX_WORD_W)
	) u_rx_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(rx_push),
		.in_ready(rx_in_ready),
		.in_data({rx_link_chan, rx_link_word}),
		.out_valid(rx_word_valid),
		.out_ready(rx_word_ready),
		.out_data({rx_word_chan, rx_word_data})
	);

	php_buf2 #(
		.WIDTH(php_pkg::PHP_TX_WORD_W)
	) u_tx_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_byte),
		.out_valid(tx_buf_valid),
		.out_ready(tx_pop),
		.out_data(tx_buf_data)
	);

	// System domain: receive words, framing errors, transmit requests
	always_comb begin
		next_s = s;
		next_s.rxs = {s.rxs[1:0], rx_link_tog};
		next_s.errs = {s.errs[1:0], rx_link_err};
		next_s.reqs = {s.reqs[1:0], t.req};
		// Link words are held a full slot, far longer than the sync delay
		rx_push = s.rxs[2] ^ s.rxs[1];
		next_s.rx_overrun = rx_push & ~rx_in_ready;
		next_s.rx_frame_err = s.errs[2] ^ s.errs[1];
		req_new = s.reqs[2] ^ s.reqs[1];
		// Channel number changes with its toggle and stays steady a whole slot after it
		need = tx_slot_en[t.req_chan];
		tx_pop = req_new & need;
		next_s.tx_underrun = 1'b0;
		if (req_new) begin
			next_s.ack = ~s.ack;
			next_s.reply_act = need & tx_buf_valid;
			if (tx_buf_valid) begin
				next_s.reply = tx_buf_data;
			end else begin
				next_s.reply = php_pkg::PHP_IDLE_BYTE;
			end
			next_s.tx_underrun = need & ~tx_buf_valid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Transmit link domain
	php_pkg::php_fmt_t tf;
	logic [8:0] tlast;
	logic [8:0] c;
	logic [8:0] bp;
	logic [5:0] ns;
	logic tedge;
	logic fbit;
	logic own;

	always_comb begin
		next_t = t;
		next_t.p = {t.p[0], transmit_frame_pulse};
		next_t.pl = t.p[1];
		next_t.cf1 = {fmt, odd_slots};
		next_t.cf2 = t.cf1;
		next_t.aks = {t.aks[1:0], s.ack};
		tf = php_pkg::php_fmt_t'(t.cf2[2:1]);
		tlast = php_pkg::php_frame_last(tf);
		tedge = t.p[1] & ~t.pl;
		if (t.cnt == tlast) begin
			c = 9'h000;
		end else begin
			c = t.cnt + 9'h001;
		end
		if (tedge) begin
			// Two sync stages late: the line already shows bit two
			c = php_pkg::PHP_TX_LAG;
			next_t.synced = 1'b1;
		end
		next_t.cnt = c;
		// Reply is stable once its ack toggle is seen
		if (t.aks[2] ^ t.aks[1]) begin
			next_t.pend = s.reply;
			// A reply for a slot already gone is kept off the line
			next_t.pact = s.reply_act & ~t.late;
			next_t.late = 1'b0;
		end
		fbit = 1'b0;
		if (tf == php_pkg::PHP_T1_1544 && c == 9'h000) begin
			fbit = 1'b1;
		end
		// The framing bit shifts every slot of the long frame by one
		if (tf == php_pkg::PHP_T1_1544) begin
			bp = c - 9'h001;
		end else begin
			bp = c;
		end
		// Double rate: two controllers share the highway, one per slot parity
		if (tf == php_pkg::PHP_DOUBLE) begin
			own = (bp[3] == t.cf2[0]);
			ns = bp[8:3] + 6'h02;
		end else begin
			own = 1'b1;
			ns = bp[8:3] + 6'h01;
		end
		if (tf == php_pkg::PHP_T1_1544 || tf == php_pkg::PHP_T1_1536) begin
			if (ns >= php_pkg::PHP_T1_SLOTS) begin
				ns = ns - php_pkg::PHP_T1_SLOTS;
			end
		end
		next_t.dout = t.sh[7];
		next_t.sh = {t.sh[6:0], 1'b0};
		if (fbit) begin
			next_t.act = 1'b0;
		end else if (bp[2:0] == 3'h0) begin
			if (own) begin
				next_t.dout = next_t.pend[7];
				next_t.sh = {next_t.pend[6:0], 1'b0};
				next_t.act = next_t.pact;
				// A late reply leaves the slot released rather than repeated
				next_t.pact = 1'b0;
				next_t.late = t.aks[1] ^ t.req;
				next_t.req = ~t.req;
				if (tf == php_pkg::PHP_DOUBLE) begin
					next_t.req_chan = ns[5:1];
				end else begin
					next_t.req_chan = ns[4:0];
				end
			end else begin
				next_t.act = 1'b0;
			end
		end
		next_t.oe_n = ~(next_t.synced & next_t.act);
	end

	// Own clock, no tie to the receive side
	always_ff @(posedge transmit_bit_clock or negedge link_rst_n[1]) begin
		if (!link_rst_n[1]) begin
			t <= TX_RESET;
		end else begin
			t <= next_t;
		end
	end

	assign tx_serial_out = t.dout;
	assign tx_serial_oe_n = t.oe_n;
	assign rx_overrun = s.rx_overrun;
	assign rx_frame_err = s.rx_frame_err;
	assign tx_underrun = s.tx_underrun;
endmodule: php_serial_port
